// file: src/interval_timer.sv
// Down-counter that measures a short interval in clock cycles
`timescale 1ns/1ns
module interval_timer (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             start,
   input  wire pd_cfg_pkg::tmr_t start_count,
   output logic                  running
);

   pd_cfg_pkg::tmr_t count_reg;

   // Load on start, then count down to idle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_reg <= pd_cfg_pkg::TMR_IDLE;
      end else if (start) begin
         count_reg <= start_count;
      end else if (count_reg != pd_cfg_pkg::TMR_IDLE) begin
         count_reg <= count_reg - pd_cfg_pkg::tmr_t'(1);
      end
   end

   assign running = (count_reg != pd_cfg_pkg::TMR_IDLE);

endmodule : interval_timer

// file: src/pd_cfg_pkg.sv
// Shared constants, state types and pin groups for the power-down and configuration-mode block
package pd_cfg_pkg;

   // Clock and documented intervals
   localparam int CLK_PERIOD_NS = 10;
   localparam int OUT_LAG_NS    = 10;      // Output lag after the input side changes
   localparam int SETTLE_NS     = 50;      // Settling time after power-down release
   localparam int MIN_PULSE_NS  = 50;      // Least low time of the power-down input

   // Timer width and derived cycle counts
   localparam int TMR_W = 4;
   typedef logic [TMR_W-1:0] tmr_t;
   localparam tmr_t OUT_LAG_CYC = tmr_t'((OUT_LAG_NS / CLK_PERIOD_NS) > 0 ?
                                         (OUT_LAG_NS / CLK_PERIOD_NS) : 1);
   localparam tmr_t SETTLE_CYC  = tmr_t'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam tmr_t TMR_IDLE    = 4'h0;

   // Power-down sequencing states
   typedef enum logic [2:0] {PD_RUN, PD_ENTER, PD_DOWN, PD_WAKE_IN, PD_WAKE_OUT} pd_state_e;

   // Configuration progress states
   typedef enum logic [1:0] {CFG_CLEAR, CFG_SAMPLE, CFG_LOAD, CFG_USER} cfg_state_e;

   // Loading modes chosen by the straps
   typedef enum logic [1:0] {LOAD_SLAVE_SERIAL, LOAD_MASTER_SERIAL, LOAD_EXPRESS} load_mode_e;

   // Input pins as seen by the core
   typedef struct packed {
      logic       mode_strap_hi;
      logic       mode_strap_lo;
      logic       done;
      logic       config_clock;
      logic       scan_out;
      logic       chain_select;
      logic [7:0] data;
      logic [7:0] user;
   } pin_in_s;

   // Buffer, reset and pull-up controls
   typedef struct packed {
      logic input_enable;
      logic output_enable;
      logic global_set_reset;
      logic pullup_enable;
      logic strap_pullup_enable;
   } pin_en_s;

   // Values after reset
   localparam pin_en_s EN_RESET = '{input_enable: 1'b1, output_enable: 1'b1,
                                    global_set_reset: 1'b0, pullup_enable: 1'b1,
                                    strap_pullup_enable: 1'b1};

endpackage : pd_cfg_pkg

// file: src/power_down_and_config_mode.sv
// Power-down sequencing and configuration-mode selection for a programmable logic device
`timescale 1ns/1ns
module power_down_and_config_mode #(
   parameter bit TWO_STRAPS = 1'b1
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire logic                   power_down_n,
   input  wire logic                   program_n,
   input  wire pd_cfg_pkg::pin_in_s    pins,
   input  wire logic                   load_finished,
   input  wire logic                   load_error,
   input  wire logic                   user_init_out,
   input  wire logic                   user_init_oe,
   output pd_cfg_pkg::pin_in_s         pins_seen,
   output pd_cfg_pkg::pin_en_s         buffers,
   output pd_cfg_pkg::load_mode_e      load_mode,
   output logic                        configured,
   output logic                        config_restart,
   output logic                        init_out,
   output logic                        init_oe,
   output logic                        init_status_valid,
   output logic                        done_out,
   output logic                        done_oe,
   output logic                        high_during_config,
   output logic                        low_during_config_n,
   output logic                        scan_enable,
   output logic                        device_ready,
   output logic [7:0]                  cfg_word,
   output logic                        cfg_word_valid,
   output logic                        cfg_word_is_byte
);

   // Strap decode for both device variants
   function automatic pd_cfg_pkg::load_mode_e decode_mode(input logic hi, input logic lo);
      pd_cfg_pkg::load_mode_e m;
      m = pd_cfg_pkg::LOAD_SLAVE_SERIAL;
      if (!TWO_STRAPS) begin
         m = lo ? pd_cfg_pkg::LOAD_SLAVE_SERIAL : pd_cfg_pkg::LOAD_MASTER_SERIAL;
      end else if (!hi) begin
         m = pd_cfg_pkg::LOAD_EXPRESS;
      end else begin
         m = lo ? pd_cfg_pkg::LOAD_SLAVE_SERIAL : pd_cfg_pkg::LOAD_MASTER_SERIAL;
      end
      return m;
   endfunction : decode_mode

   pd_cfg_pkg::pd_state_e  pd_state_reg;
   pd_cfg_pkg::pd_state_e  pd_next;
   pd_cfg_pkg::cfg_state_e cfg_state_reg;
   pd_cfg_pkg::cfg_state_e cfg_next;
   pd_cfg_pkg::pin_in_s    pins_seen_reg;
   pd_cfg_pkg::pin_en_s    en_reg;
   pd_cfg_pkg::load_mode_e load_mode_reg;
   logic                   lag_start;
   logic                   lag_running;
   logic                   settle_start;
   logic                   settle_running;
   logic                   in_en_next;
   logic                   out_en_next;
   logic                   gsr_next;
   logic                   restart;
   logic                   load_error_reg;
   logic                   config_clock_prev_reg;
   logic                   config_clock_rise;
   logic                   device_ready_reg;
   logic                   config_restart_reg;
   logic                   init_out_reg;
   logic                   init_oe_reg;
   logic                   init_valid_reg;
   logic                   done_oe_reg;
   logic                   hdc_reg;
   logic                   ldc_n_reg;
   logic                   scan_enable_reg;
   logic [7:0]             cfg_word_reg;
   logic                   cfg_word_valid_reg;
   logic                   cfg_word_is_byte_reg;

   // Output lag and settle interval timers
   interval_timer u_lag_timer (
      .core_clk    (core_clk),
      .rst         (rst),
      .start       (lag_start),
      .start_count (pd_cfg_pkg::OUT_LAG_CYC),
      .running     (lag_running)
   );

   interval_timer u_settle_timer (
      .core_clk    (core_clk),
      .rst         (rst),
      .start       (settle_start),
      .start_count (pd_cfg_pkg::SETTLE_CYC),
      .running     (settle_running)
   );

   // Power-down sequencer: ordered entry and exit
   always_comb begin
      pd_next      = pd_state_reg;
      lag_start    = 1'b0;
      settle_start = 1'b0;
      case (pd_state_reg)
         pd_cfg_pkg::PD_RUN: begin
            if (!power_down_n) begin
               pd_next   = pd_cfg_pkg::PD_ENTER;
               lag_start = 1'b1;
            end
         end
         pd_cfg_pkg::PD_ENTER: begin
            if (!lag_running) begin
               pd_next = pd_cfg_pkg::PD_DOWN;
            end
         end
         pd_cfg_pkg::PD_DOWN: begin
            if (power_down_n) begin
               pd_next      = pd_cfg_pkg::PD_WAKE_IN;
               settle_start = 1'b1;
            end
         end
         pd_cfg_pkg::PD_WAKE_IN: begin
            if (!power_down_n) begin
               pd_next = pd_cfg_pkg::PD_DOWN;
            end else begin
               pd_next   = pd_cfg_pkg::PD_WAKE_OUT;
               lag_start = 1'b1;
            end
         end
         pd_cfg_pkg::PD_WAKE_OUT: begin
            if (!power_down_n) begin
               pd_next = pd_cfg_pkg::PD_DOWN;
            end else if (!lag_running) begin
               pd_next = pd_cfg_pkg::PD_RUN;
            end
         end
         default: begin
            pd_next = pd_cfg_pkg::PD_RUN;
         end
      endcase
   end

   // Buffer and reset controls decoded from the next sequencer state
   assign in_en_next  = (pd_next == pd_cfg_pkg::PD_RUN) || (pd_next == pd_cfg_pkg::PD_WAKE_IN) ||
                        (pd_next == pd_cfg_pkg::PD_WAKE_OUT);
   assign out_en_next = (pd_next == pd_cfg_pkg::PD_RUN) ||
                        (pd_next == pd_cfg_pkg::PD_ENTER);
   assign gsr_next    = (pd_next == pd_cfg_pkg::PD_ENTER) || (pd_next == pd_cfg_pkg::PD_DOWN) ||
                        (pd_next == pd_cfg_pkg::PD_WAKE_IN);

   // Sequencer state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pd_state_reg <= pd_cfg_pkg::PD_RUN;
      end else begin
         pd_state_reg <= pd_next;
      end
   end

   // Buffer, reset and pull-up flops
   always_ff @(posedge core_clk) begin
      if (rst) begin
         en_reg <= pd_cfg_pkg::EN_RESET;
      end else begin
         en_reg.input_enable        <= in_en_next;
         en_reg.output_enable       <= out_en_next;
         en_reg.global_set_reset    <= gsr_next;
         en_reg.pullup_enable       <= in_en_next;
         en_reg.strap_pullup_enable <= in_en_next && (cfg_next != pd_cfg_pkg::CFG_USER);
      end
   end

   // Gated view of the input pins, forced low while inputs are off
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pins_seen_reg <= '0;
      end else begin
         pins_seen_reg <= in_en_next ? pins : '0;
      end
   end

   // Ready once the settle interval after release has passed
   always_ff @(posedge core_clk) begin
      if (rst) begin
         device_ready_reg <= 1'b0;
      end else begin
         device_ready_reg <= (pd_next == pd_cfg_pkg::PD_RUN) && !settle_running && !settle_start;
      end
   end

   // Configuration progress; reprogram uses the raw pin
   always_comb begin
      cfg_next = cfg_state_reg;
      restart  = 1'b0;
      if (!program_n) begin
         cfg_next = pd_cfg_pkg::CFG_CLEAR;
      end else if (pd_state_reg != pd_cfg_pkg::PD_RUN && cfg_state_reg != pd_cfg_pkg::CFG_USER) begin
         cfg_next = pd_cfg_pkg::CFG_CLEAR;
         restart  = (cfg_state_reg != pd_cfg_pkg::CFG_CLEAR);
      end else begin
         case (cfg_state_reg)
            pd_cfg_pkg::CFG_CLEAR:  cfg_next = pd_cfg_pkg::CFG_SAMPLE;
            pd_cfg_pkg::CFG_SAMPLE: cfg_next = pd_cfg_pkg::CFG_LOAD;
            pd_cfg_pkg::CFG_LOAD: begin
               if (load_finished && !load_error_reg) begin
                  cfg_next = pd_cfg_pkg::CFG_USER;
               end
            end
            pd_cfg_pkg::CFG_USER:   cfg_next = pd_cfg_pkg::CFG_USER;
            default:                cfg_next = pd_cfg_pkg::CFG_CLEAR;
         endcase
      end
   end

   // Configuration state and restart pulse
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfg_state_reg      <= pd_cfg_pkg::CFG_CLEAR;
         config_restart_reg <= 1'b0;
      end else begin
         cfg_state_reg      <= cfg_next;
         config_restart_reg <= restart;
      end
   end

   // Strap sampling only in the sample state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         load_mode_reg <= pd_cfg_pkg::LOAD_SLAVE_SERIAL;
      end else if (cfg_state_reg == pd_cfg_pkg::CFG_SAMPLE) begin
         load_mode_reg <= decode_mode(pins_seen_reg.mode_strap_hi, pins_seen_reg.mode_strap_lo);
      end
   end

   // Sticky load error, cleared by a new clearing pass; set wins
   always_ff @(posedge core_clk) begin
      if (rst) begin
         load_error_reg <= 1'b0;
      end else if (cfg_state_reg == pd_cfg_pkg::CFG_LOAD && load_error) begin
         load_error_reg <= 1'b1;
      end else if (cfg_state_reg == pd_cfg_pkg::CFG_CLEAR) begin
         load_error_reg <= 1'b0;
      end
   end

   // Status, completion, config markers and scan enable
   always_ff @(posedge core_clk) begin
      if (rst) begin
         init_out_reg    <= 1'b0;
         init_oe_reg     <= 1'b1;
         init_valid_reg  <= 1'b0;
         done_oe_reg     <= 1'b1;
         hdc_reg         <= 1'b1;
         ldc_n_reg       <= 1'b0;
         scan_enable_reg <= 1'b0;
      end else begin
         scan_enable_reg <= (pd_next == pd_cfg_pkg::PD_RUN);
         if (pd_next != pd_cfg_pkg::PD_RUN) begin
            init_out_reg   <= 1'b0;
            init_oe_reg    <= 1'b0;
            init_valid_reg <= 1'b0;
            done_oe_reg    <= 1'b0;
            hdc_reg        <= 1'b0;
            ldc_n_reg      <= 1'b1;
         end else if (cfg_next == pd_cfg_pkg::CFG_USER) begin
            init_out_reg   <= user_init_out;
            init_oe_reg    <= user_init_oe;
            init_valid_reg <= 1'b0;
            done_oe_reg    <= 1'b0;
            hdc_reg        <= 1'b0;
            ldc_n_reg      <= 1'b1;
         end else begin
            init_out_reg   <= 1'b0;
            init_oe_reg    <= (cfg_next == pd_cfg_pkg::CFG_CLEAR) || load_error_reg ||
                              (cfg_state_reg == pd_cfg_pkg::CFG_LOAD && load_error);
            init_valid_reg <= 1'b1;
            done_oe_reg    <= 1'b1;
            hdc_reg        <= 1'b1;
            ldc_n_reg      <= 1'b0;
         end
      end
   end

   // Configuration clock edge from the gated view
   assign config_clock_rise = pins_seen_reg.config_clock && !config_clock_prev_reg;

   // Data capture: a byte per clock in express, else one bit
   always_ff @(posedge core_clk) begin
      if (rst) begin
         config_clock_prev_reg        <= 1'b0;
         cfg_word_reg         <= 8'h00;
         cfg_word_valid_reg   <= 1'b0;
         cfg_word_is_byte_reg <= 1'b0;
      end else begin
         config_clock_prev_reg      <= pins_seen_reg.config_clock;
         cfg_word_valid_reg <= 1'b0;
         if (cfg_state_reg == pd_cfg_pkg::CFG_LOAD && config_clock_rise) begin
            cfg_word_valid_reg   <= 1'b1;
            cfg_word_is_byte_reg <= (load_mode_reg == pd_cfg_pkg::LOAD_EXPRESS);
            cfg_word_reg         <= (load_mode_reg == pd_cfg_pkg::LOAD_EXPRESS) ?
                                    pins_seen_reg.data : {7'h00, pins_seen_reg.data[0]};
         end
      end
   end

   // Outputs straight from flops, except configured (decoded from the state) and done_out (tied low)
   assign pins_seen           = pins_seen_reg;
   assign buffers             = en_reg;
   assign load_mode           = load_mode_reg;
   assign configured          = (cfg_state_reg == pd_cfg_pkg::CFG_USER);
   assign config_restart      = config_restart_reg;
   assign init_out            = init_out_reg;
   assign init_oe             = init_oe_reg;
   assign init_status_valid   = init_valid_reg;
   assign done_out            = 1'b0;
   assign done_oe             = done_oe_reg;
   assign high_during_config  = hdc_reg;
   assign low_during_config_n = ldc_n_reg;
   assign scan_enable         = scan_enable_reg;
   assign device_ready        = device_ready_reg;
   assign cfg_word            = cfg_word_reg;
   assign cfg_word_valid      = cfg_word_valid_reg;
   assign cfg_word_is_byte    = cfg_word_is_byte_reg;

   // Checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   a_entry_order: assert property ((pd_state_reg == pd_cfg_pkg::PD_RUN && !power_down_n) |=>
      (!en_reg.input_enable && en_reg.global_set_reset && en_reg.output_enable)
      ##[1:3] !en_reg.output_enable) else $error("power-down entry order wrong");
   a_exit_order: assert property ((pd_state_reg == pd_cfg_pkg::PD_DOWN && power_down_n) |=>
      (en_reg.input_enable && en_reg.global_set_reset && !en_reg.output_enable)
      ##1 (!en_reg.global_set_reset && !en_reg.output_enable)
      ##[1:3] en_reg.output_enable) else $error("power-down exit order wrong");
   a_inputs_low: assert property (!en_reg.input_enable |->
      (pins_seen_reg == '0 && !en_reg.pullup_enable && !en_reg.strap_pullup_enable))
      else $error("inputs not forced low");
   a_gsr_held: assert property ((pd_state_reg == pd_cfg_pkg::PD_DOWN) |->
      (en_reg.global_set_reset && !en_reg.output_enable)) else $error("reset not held");
   a_program_works: assert property (!program_n |=>
      (cfg_state_reg == pd_cfg_pkg::CFG_CLEAR)) else $error("reprogram ignored");
   a_config_restart: assert property ((cfg_state_reg != pd_cfg_pkg::CFG_USER &&
      pd_state_reg != pd_cfg_pkg::PD_RUN) |=> (cfg_state_reg == pd_cfg_pkg::CFG_CLEAR))
      else $error("configuration not restarted");
   a_config_kept: assert property ((cfg_state_reg == pd_cfg_pkg::CFG_USER && program_n) |=>
      (cfg_state_reg == pd_cfg_pkg::CFG_USER)) else $error("configuration lost");
   a_pins_released: assert property ((pd_state_reg == pd_cfg_pkg::PD_DOWN) |->
      (!done_oe_reg && !init_oe_reg && !init_valid_reg && !scan_enable_reg))
      else $error("pins driven in power-down");
   a_mode_decode: assert property ((cfg_state_reg == pd_cfg_pkg::CFG_SAMPLE) |=>
      (load_mode_reg == decode_mode($past(pins_seen_reg.mode_strap_hi),
                                    $past(pins_seen_reg.mode_strap_lo))))
      else $error("strap decode wrong");
   a_express_byte: assert property ((cfg_state_reg == pd_cfg_pkg::CFG_LOAD && config_clock_rise &&
      load_mode_reg == pd_cfg_pkg::LOAD_EXPRESS) |=>
      (cfg_word_valid_reg && cfg_word_is_byte_reg && cfg_word_reg == $past(pins_seen_reg.data)))
      else $error("express byte not taken");

endmodule : power_down_and_config_mode

// file: tb/pd_controller.sv
// Board controller model that drives the power-down request pin
`timescale 1ns/1ns
module pd_controller (
   input  wire logic core_clk,
   output logic      power_down_n
);
   int low_cycles = 0;

   // Idle high, so configuration runs undisturbed unless a test cuts it on purpose
   initial power_down_n = 1'b1;

   // Count how long the request has been held low
   always @(posedge core_clk) begin
      low_cycles <= power_down_n ? 0 : low_cycles + 1;
   end

   // Pull the request low just after a clock edge, with no early tristate or reset first
   task automatic enter_down();
      @(posedge core_clk);
      power_down_n <= 1'b0;
   endtask : enter_down

   // Release only once the least low time has been held
   task automatic leave_down();
      @(posedge core_clk);
      while (low_cycles * pd_cfg_pkg::CLK_PERIOD_NS < pd_cfg_pkg::MIN_PULSE_NS) begin
         @(posedge core_clk);
      end
      power_down_n <= 1'b1;
   endtask : leave_down
endmodule : pd_controller

// file: tb/power_down_and_config_mode_tb.sv
// Self-checking bench for power-down sequencing and configuration-mode selection
`timescale 1ns/1ns
module power_down_and_config_mode_tb;
   logic                   core_clk, rst, power_down_n, program_n, load_finished, load_error;
   logic                   user_init_out, user_init_oe, configured, config_restart, init_out;
   logic                   init_oe, init_status_valid, done_out, done_oe, high_during_config;
   logic                   low_during_config_n, scan_enable, device_ready;
   logic                   cfg_word_valid, cfg_word_is_byte;
   pd_cfg_pkg::load_mode_e load_mode_one;
   int                     n_restarts = 0;
   logic [7:0]             cfg_word;
   logic [8:0]             exp_q[$];
   pd_cfg_pkg::pin_in_s    pins, pins_seen;
   pd_cfg_pkg::pin_en_s    buffers;
   pd_cfg_pkg::load_mode_e load_mode;
   pd_cfg_pkg::load_mode_e mode_tab[4] = '{pd_cfg_pkg::LOAD_EXPRESS, pd_cfg_pkg::LOAD_EXPRESS,
      pd_cfg_pkg::LOAD_MASTER_SERIAL, pd_cfg_pkg::LOAD_SLAVE_SERIAL};
   int                     fails = 0;
   int                     n_checks = 0;
   int                     cycles = 0;

   pd_controller ctl (.core_clk(core_clk), .power_down_n(power_down_n));

   power_down_and_config_mode DUT (.core_clk(core_clk), .rst(rst), .power_down_n(power_down_n),
      .program_n(program_n), .pins(pins), .load_finished(load_finished),
      .load_error(load_error), .user_init_out(user_init_out), .user_init_oe(user_init_oe),
      .pins_seen(pins_seen), .buffers(buffers), .load_mode(load_mode), .configured(configured),
      .config_restart(config_restart), .init_out(init_out), .init_oe(init_oe),
      .init_status_valid(init_status_valid), .done_out(done_out), .done_oe(done_oe),
      .high_during_config(high_during_config), .low_during_config_n(low_during_config_n),
      .scan_enable(scan_enable), .device_ready(device_ready), .cfg_word(cfg_word),
      .cfg_word_valid(cfg_word_valid), .cfg_word_is_byte(cfg_word_is_byte));

   // Single-strap variant, watched only for its load mode
   power_down_and_config_mode #(.TWO_STRAPS(1'b0)) dut_one_strap (.core_clk(core_clk), .rst(rst),
      .power_down_n(power_down_n), .program_n(program_n), .pins(pins),
      .load_finished(load_finished), .load_error(load_error), .user_init_out(user_init_out),
      .user_init_oe(user_init_oe), .pins_seen(), .buffers(), .load_mode(load_mode_one),
      .configured(), .config_restart(), .init_out(), .init_oe(), .init_status_valid(),
      .done_out(), .done_oe(), .high_during_config(), .low_during_config_n(), .scan_enable(),
      .device_ready(), .cfg_word(), .cfg_word_valid(), .cfg_word_is_byte());

   // Free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test

   task automatic check_bit(string what, logic exp, logic got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask : check_bit

   task automatic check_val(string what, logic [21:0] exp, logic [21:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val

   // Compare a capture, its byte flag and all eight data bits, against its note
   task automatic compare_word(logic [8:0] exp, logic [8:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] cfg_word expected %h seen %h", exp, got);
      end
   endtask : compare_word

   // Let n edges pass, then sample once their updates have landed
   task automatic step(int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   // Set the straps and restart configuration, ending in the loading phase
   task automatic reprogram(logic hi, logic lo);
      @(posedge core_clk);
      pins.mode_strap_hi <= hi;
      pins.mode_strap_lo <= lo;
      program_n <= 1'b0;
      @(posedge core_clk);
      program_n <= 1'b1;
      step(6);
   endtask : reprogram

   // One config_clock period, three cycles high and three low, noting the expected capture
   task automatic send_word(logic [7:0] d, logic is_byte);
      @(posedge core_clk);
      pins.data <= d;
      pins.config_clock <= 1'b1;
      exp_q.push_back(is_byte ? {1'b1, d} : {1'b0, 7'h00, d[0]});
      step(2);
      @(posedge core_clk);
      pins.config_clock <= 1'b0;
      step(2);
   endtask : send_word

   // Watch the outputs: match captures against the oldest note, remember restarts
   always @(posedge core_clk) begin
      if (config_restart === 1'b1) n_restarts++;
      if (cfg_word_valid === 1'b1) begin
         if (exp_q.size() == 0) check_bit("capture noted", 1'b1, 1'b0);
         else compare_word(exp_q.pop_front(), {cfg_word_is_byte, cfg_word});
      end
   end

   // Cut a hang short well beyond the expected run length
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         end_of_test();
      end
   end

   initial begin
      rst = 1'b1;
      program_n = 1'b1;
      pins = '0;
      pins.mode_strap_hi = 1'b1;
      pins.mode_strap_lo = 1'b1;
      load_finished = 1'b0;
      load_error = 1'b0;
      user_init_out = 1'b0;
      user_init_oe = 1'b1;
      void'($urandom(32'hD4AECA04));
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      step(1);
      check_val("buffers", 22'(pd_cfg_pkg::EN_RESET), 22'(buffers));
      // Every strap pair picks its mode; later strap changes are ignored
      for (int i = 0; i < 4; i++) begin
         reprogram(i[1], i[0]);
         check_val("load_mode", 22'(mode_tab[i]), 22'(load_mode));
         check_val("one strap", 22'(i[0] ? pd_cfg_pkg::LOAD_SLAVE_SERIAL :
            pd_cfg_pkg::LOAD_MASTER_SERIAL), 22'(load_mode_one));
         @(posedge core_clk);
         pins.mode_strap_hi <= ~i[1];
         step(3);
         check_val("load_mode", 22'(mode_tab[i]), 22'(load_mode));
      end
      $display("test strap decode done");
      // Serial capture takes one bit, express one whole byte per clock
      send_word(8'($urandom()), 1'b0);
      reprogram(1'b0, 1'b0);
      for (int i = 0; i < 4; i++) send_word(8'($urandom()), 1'b1);
      step(2);
      check_val("pending", 22'h0, 22'(exp_q.size()));
      $display("test capture done");
      // Status pins while loading, then user operation
      check_bit("hdc", 1'b1, high_during_config);
      check_bit("ldc_n", 1'b0, low_during_config_n);
      check_bit("init_valid", 1'b1, init_status_valid);
      @(posedge core_clk);
      load_finished <= 1'b1;
      user_init_out <= 1'b1;
      user_init_oe <= 1'b0;
      @(posedge core_clk);
      load_finished <= 1'b0;
      step(3);
      check_bit("configured", 1'b1, configured);
      check_bit("ldc_n", 1'b1, low_during_config_n);
      check_bit("init_oe", user_init_oe, init_oe);
      check_bit("init_out", user_init_out, init_out);
      $display("test finish done");
      // Power-down entry while configured
      pins.user <= 8'($urandom());
      ctl.enter_down();
      step(2);
      check_val("entry", 22'h6, 22'(buffers[4:1]));
      check_val("pins_seen", 22'h0, 22'(pins_seen));
      check_bit("scan", 1'b0, scan_enable);
      check_bit("done_oe", 1'b0, done_oe);
      check_bit("done_out", 1'b0, done_out);
      check_bit("init_valid", 1'b0, init_status_valid);
      step(2);
      check_val("outputs off", 22'h2, 22'(buffers[4:1]));
      check_bit("configured", 1'b1, configured);
      @(posedge core_clk);
      program_n <= 1'b0;
      @(posedge core_clk);
      program_n <= 1'b1;
      step(2);
      check_bit("configured", 1'b0, configured);
      ctl.leave_down();
      step(1);
      check_val("wake inputs", 22'hB, 22'(buffers[4:1]));
      step(1);
      check_val("wake gsr", 22'h9, 22'(buffers[4:1]));
      check_val("pins_seen", 22'(pins), 22'(pins_seen));
      step(2);
      check_val("wake outputs", 22'hD, 22'(buffers[4:1]));
      check_bit("scan", 1'b1, scan_enable);
      check_bit("ready", 1'b0, device_ready);
      step(3);
      check_bit("ready", 1'b1, device_ready);
      $display("test power-down done");
      // Power-down in mid-load restarts configuration and resamples the straps
      reprogram(1'b1, 1'b1);
      ctl.enter_down();
      pins.mode_strap_lo <= 1'b0;
      step(3);
      check_val("restarts", 22'h1, 22'(n_restarts));
      ctl.leave_down();
      step(14);
      check_val("load_mode", 22'(pd_cfg_pkg::LOAD_MASTER_SERIAL), 22'(load_mode));
      $display("test restart done");
      end_of_test();
   end
endmodule : power_down_and_config_mode_tb
